// >>> rtl/mffb_pkg.sv
// Purpose: shared constants and carriers for the monitor formatter and fan boost block
// Assumes: 25 MHz clock, APB register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package mffb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLIM = 8'h04;
  localparam logic [7:0] OFS_TLIM = 8'h08;
  localparam logic [7:0] OFS_TACHLIM01 = 8'h0c;
  localparam logic [7:0] OFS_TACHLIM23 = 8'h10;
  localparam logic [7:0] OFS_TEMP8 = 8'h14;
  localparam logic [7:0] OFS_STAT_B = 8'h18;
  localparam logic [7:0] OFS_STAT_H = 8'h1c;
  localparam logic [7:0] OFS_EXT = 8'h20;
  localparam logic [7:0] OFS_VLIM = 8'h40;
  localparam logic [7:0] OFS_VOLT = 8'h80;

  localparam int CTRL_TEN_BIT = 0;
  localparam int CTRL_HYST_LSB = 4;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CTRL_BIND_LSB = 12;
  localparam int CTRL_TMO_LSB = 20;

  localparam int ST_DIODE_LSB = 0;
  localparam int ST_TLIM_LSB = 4;
  localparam int ST_TACH_LSB = 8;
  localparam int ST_VOLT_LSB = 12;

  localparam logic [31:0] CTRL_RST = 32'h00ff_ff00;
  localparam logic [31:0] BLIM_RST = 32'h2323_3c3c;
  localparam logic [7:0] TLIM_RST = 8'h80;
  localparam logic [15:0] TACHLIM_RST = 16'hffff;
  localparam logic [7:0] VLO_RST = 8'h00;
  localparam logic [7:0] VHI_RST = 8'hff;

  localparam logic [7:0] TEMP_MASK = 8'h80;
  localparam logic [7:0] TEMP_FAULT = 8'h80;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam logic [7:0] CODE_NOM_POS = 8'hc0;
  localparam logic [7:0] CODE_NOM_NEG = 8'h40;

  typedef struct packed {
    logic valid;
    logic [1:0] zone;
    logic open_ckt;
    logic short_ckt;
    logic [8:0] t_half;
    logic [11:0] t_sixteenth;
  } mffb_temp_conv_t;

  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [7:0] code;
  } mffb_volt_conv_t;

  typedef struct packed {
    logic valid;
    logic [1:0] fan;
    logic [15:0] count;
  } mffb_tach_meas_t;
endpackage

// >>> rtl/mffb_top.sv
// Purpose: format monitor results, flag diode faults, compare limits, raise fan boost
// Assumes: converters and tach counters run on mclk_i and deliver one-cycle valid pulses
// Notes: status registers are sticky and cleared by writing ones
// What this block does
// - temperature bytes are signed, one degree per step
// - limit value 80h masks that channel's limit flag; a boost limit of 80h is not masked
// - unfiltered extended value, half degree at bit7
// - filtered extended value, fraction in upper nibble
// - hysteresis field is unsigned four-bit value
// - check diode open/short before each update
// - diode fault loads 80h into temperature
// - temperature boost drives both outputs full
// - boost when zone exceeds its limit
// - release at or below limit minus hysteresis
// - reset limits 60 for zones 0-1, 35 otherwise
// - tach boost drives bound outputs full
// - tach error when count exceeds limit
// - hold bound outputs full for timeout after
// - recurring error cancels and later restarts timeout
// - voltages are unsigned 8-bit codes
// - twelve-volt inputs span 00h to FFh linearly
// - negative rail nominal reads 40h
// - limit violations set both mirrored status sets
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module mffb_top #(
  parameter int unsigned TICK_CYCLES = mffb_pkg::TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire mffb_pkg::mffb_temp_conv_t temp_conv_i,
  input wire mffb_pkg::mffb_volt_conv_t volt_conv_i,
  input wire mffb_pkg::mffb_tach_meas_t tach_meas_i,
  input wire logic [7:0] duty_a_i,
  input wire logic [7:0] duty_b_i,
  output logic [7:0] fan_drive_out_a,
  output logic [7:0] fan_drive_out_b,
  output logic [1:0] boost_active_o
);
  initial begin
    if (TICK_CYCLES < 1) begin
      $error("TICK_CYCLES must be at least one");
    end
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0][7:0] blim;
    logic [3:0][7:0] tlim;
    logic [3:0][15:0] tachlim;
    logic [8:0][7:0] vlo;
    logic [8:0][7:0] vhi;
    logic [8:0][7:0] volt;
    logic [3:0][7:0] temp8;
    logic [3:0][15:0] ext9;
    logic [3:0][15:0] ext12;
    logic [3:0] tach_err;
    logic [3:0] zboost;
    logic [31:0] st_b;
    logic [31:0] st_h;
    logic [1:0][7:0] hold;
    logic [1:0] hold_act;
    logic [31:0] tick_cnt;
    logic [1:0][7:0] drive;
    logic [1:0] boost;
    logic [31:0] rdata;
  } mffb_state_t;

  mffb_state_t state_r;
  mffb_state_t state_nxt;

  // signed degree compare, a > b
  function automatic logic temp_gt(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) > $signed(b);
  endfunction

  // register decode: returns read word and hit flag
  function automatic logic [32:0] rd_word(input mffb_state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    if (a == mffb_pkg::OFS_CTRL) begin
      r = {1'b1, s.ctrl};
    end else if (a == mffb_pkg::OFS_BLIM) begin
      r = {1'b1, s.blim};
    end else if (a == mffb_pkg::OFS_TLIM) begin
      r = {1'b1, s.tlim};
    end else if (a == mffb_pkg::OFS_TACHLIM01) begin
      r = {1'b1, s.tachlim[1], s.tachlim[0]};
    end else if (a == mffb_pkg::OFS_TACHLIM23) begin
      r = {1'b1, s.tachlim[3], s.tachlim[2]};
    end else if (a == mffb_pkg::OFS_TEMP8) begin
      r = {1'b1, s.temp8};
    end else if (a == mffb_pkg::OFS_STAT_B) begin
      r = {1'b1, s.st_b};
    end else if (a == mffb_pkg::OFS_STAT_H) begin
      r = {1'b1, s.st_h};
    end else if (a[7:4] == mffb_pkg::OFS_EXT[7:4] && a[1:0] == 2'h0) begin
      r = {1'b1, s.ext12[a[3:2]], s.ext9[a[3:2]]};
    end else if (a[7:6] == mffb_pkg::OFS_VLIM[7:6] && a[1:0] == 2'h0 && a[5:2] < 4'h9) begin
      r = {1'b1, 16'h0000, s.vhi[a[5:2]], s.vlo[a[5:2]]};
    end else if (a[7:6] == mffb_pkg::OFS_VOLT[7:6] && a[1:0] == 2'h0 && a[5:2] < 4'h9) begin
      r = {1'b1, 24'h00_0000, s.volt[a[5:2]]};
    end
    return r;
  endfunction

  logic [32:0] dec_setup;
  logic [32:0] dec_acc;
  logic wr_en;

  always_comb begin
    dec_setup = rd_word(state_r, paddr_i);
    dec_acc = rd_word(state_r, paddr_i);
    pready_o = ce_i & psel_i & penable_i;
    pslverr_o = ce_i & psel_i & penable_i & ~dec_acc[32];
    prdata_o = state_r.rdata;
    fan_drive_out_a = state_r.drive[0];
    fan_drive_out_b = state_r.drive[1];
    boost_active_o = state_r.boost;
    wr_en = ce_i & psel_i & penable_i & pwrite_i & dec_acc[32];
  end

  logic [31:0] st_set;
  logic [31:0] clr_b;
  logic [31:0] clr_h;
  logic [9:0] rel_thr;
  logic [1:0] err_out;
  logic tick;
  logic [3:0] hyst;
  logic [3:0] tmask;
  logic [7:0] tbind;
  logic [7:0] tmo;
  logic [3:0] zi;
  logic [7:0] tmp;

  always_comb begin
    state_nxt = state_r;
    st_set = 32'h0000_0000;
    clr_b = 32'h0000_0000;
    clr_h = 32'h0000_0000;
    rel_thr = 10'h000;
    err_out = 2'b00;
    zi = 4'h0;
    tmp = 8'h00;
    hyst = state_r.ctrl[mffb_pkg::CTRL_HYST_LSB +: 4];
    tmask = state_r.ctrl[mffb_pkg::CTRL_MASK_LSB +: 4];
    tbind = state_r.ctrl[mffb_pkg::CTRL_BIND_LSB +: 8];
    tmo = state_r.ctrl[mffb_pkg::CTRL_TMO_LSB +: 8];
    tick = (state_r.tick_cnt == TICK_CYCLES - 1);

    // read data captured in the setup cycle
    if (psel_i && !penable_i) begin
      state_nxt.rdata = dec_setup[31:0];
    end

    state_nxt.tick_cnt = tick ? 32'h0000_0000 : state_r.tick_cnt + 32'h0000_0001;

    // diode conversion results
    if (temp_conv_i.valid) begin
      zi = {2'b00, temp_conv_i.zone};
      if (temp_conv_i.open_ckt || temp_conv_i.short_ckt) begin
        st_set[mffb_pkg::ST_DIODE_LSB + zi] = 1'b1;
        state_nxt.temp8[zi[1:0]] = mffb_pkg::TEMP_FAULT;
        state_nxt.ext9[zi[1:0]] = {mffb_pkg::TEMP_FAULT, 8'h00};
        state_nxt.ext12[zi[1:0]] = {mffb_pkg::TEMP_FAULT, 8'h00};
      end else begin
        state_nxt.temp8[zi[1:0]] = temp_conv_i.t_half[8:1];
        state_nxt.ext9[zi[1:0]] = {temp_conv_i.t_half[8:1], temp_conv_i.t_half[0], 7'h00};
        state_nxt.ext12[zi[1:0]] = {temp_conv_i.t_sixteenth, 4'h0};
      end
    end

    // voltage codes pass through unchanged; converter scaling fixes the span
    if (volt_conv_i.valid && volt_conv_i.chan < 4'h9) begin
      state_nxt.volt[volt_conv_i.chan] = volt_conv_i.code;
    end

    // tachometer limit check
    if (tach_meas_i.valid) begin
      state_nxt.tach_err[tach_meas_i.fan] =
        tach_meas_i.count > state_r.tachlim[tach_meas_i.fan];
    end

    // limit comparisons against stored values
    for (int z = 0; z < 4; z++) begin
      tmp = state_r.temp8[z];
      if (state_r.tlim[z] != mffb_pkg::TEMP_MASK && tmp != mffb_pkg::TEMP_FAULT
          && temp_gt(tmp, state_r.tlim[z])) begin
        st_set[mffb_pkg::ST_TLIM_LSB + z] = 1'b1;
      end
      if (state_r.tach_err[z]) begin
        st_set[mffb_pkg::ST_TACH_LSB + z] = 1'b1;
      end
      // boost with hysteresis
      rel_thr = 10'($signed(state_r.blim[z])) - {6'h00, hyst};
      if (temp_gt(tmp, state_r.blim[z])) begin
        state_nxt.zboost[z] = 1'b1;
      end else if ($signed(10'($signed(tmp))) <= $signed(rel_thr)) begin
        state_nxt.zboost[z] = 1'b0;
      end
    end
    for (int c = 0; c < 9; c++) begin
      if (state_r.volt[c] < state_r.vlo[c] || state_r.volt[c] > state_r.vhi[c]) begin
        st_set[mffb_pkg::ST_VOLT_LSB + c] = 1'b1;
      end
    end

    // tach boost per output with hold timeout
    for (int o = 0; o < 2; o++) begin
      for (int f = 0; f < 4; f++) begin
        if (state_r.tach_err[f] && !tmask[f] && tbind[2 * f + o]) begin
          err_out[o] = state_r.ctrl[mffb_pkg::CTRL_TEN_BIT];
        end
      end
      if (err_out[o]) begin
        state_nxt.hold[o] = tmo;
        state_nxt.hold_act[o] = 1'b1;
      end else if (state_r.hold_act[o] && tick) begin
        if (state_r.hold[o] == 8'h00) begin
          state_nxt.hold_act[o] = 1'b0;
        end else begin
          state_nxt.hold[o] = state_r.hold[o] - 8'h01;
        end
      end
      state_nxt.boost[o] = (|state_r.zboost) | err_out[o] | state_r.hold_act[o];
    end
    state_nxt.drive[0] = state_r.boost[0] ? mffb_pkg::DUTY_FULL : duty_a_i;
    state_nxt.drive[1] = state_r.boost[1] ? mffb_pkg::DUTY_FULL : duty_b_i;

    // register writes
    if (wr_en) begin
      unique case (paddr_i)
        mffb_pkg::OFS_CTRL: state_nxt.ctrl = pwdata_i;
        mffb_pkg::OFS_BLIM: state_nxt.blim = pwdata_i;
        mffb_pkg::OFS_TLIM: state_nxt.tlim = pwdata_i;
        mffb_pkg::OFS_TACHLIM01: state_nxt.tachlim[1:0] = pwdata_i;
        mffb_pkg::OFS_TACHLIM23: state_nxt.tachlim[3:2] = pwdata_i;
        mffb_pkg::OFS_STAT_B: clr_b = pwdata_i;
        mffb_pkg::OFS_STAT_H: clr_h = pwdata_i;
        default: begin
          if (paddr_i[7:6] == mffb_pkg::OFS_VLIM[7:6]) begin
            state_nxt.vlo[paddr_i[5:2]] = pwdata_i[7:0];
            state_nxt.vhi[paddr_i[5:2]] = pwdata_i[15:8];
          end
        end
      endcase
    end

    // sticky mirrored status, set wins over clear
    state_nxt.st_b = (state_r.st_b & ~clr_b) | st_set;
    state_nxt.st_h = (state_r.st_h & ~clr_h) | st_set;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= '0;
      state_r.ctrl <= mffb_pkg::CTRL_RST;
      state_r.blim <= mffb_pkg::BLIM_RST;
      state_r.tlim <= {4{mffb_pkg::TLIM_RST}};
      state_r.tachlim <= {4{mffb_pkg::TACHLIM_RST}};
      state_r.vlo <= {9{mffb_pkg::VLO_RST}};
      state_r.vhi <= {9{mffb_pkg::VHI_RST}};
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end
endmodule // mffb_top

// >>> tb/mffb_top_monitor.sv
// Purpose: port checker for mffb_top
// Assumes: one clock, async active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module mffb_top_chk (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] duty_a_i,
  input wire logic [7:0] duty_b_i,
  input wire logic [7:0] fan_drive_out_a,
  input wire logic [7:0] fan_drive_out_b,
  input wire logic [1:0] boost_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_full_a; ce_i && boost_active_o[0] |=> fan_drive_out_a == 8'hff; endproperty
  a_full_a: assert property (p_full_a) else $error("out a not full");
  property p_full_b; ce_i && boost_active_o[1] |=> fan_drive_out_b == 8'hff; endproperty
  a_full_b: assert property (p_full_b) else $error("out b not full");
  property p_pass_a;
    ce_i && !boost_active_o[0] && duty_a_i == $past(duty_a_i) |=> fan_drive_out_a == $past(duty_a_i);
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("out a not normal duty");
  property p_pass_b;
    ce_i && !boost_active_o[1] && duty_b_i == $past(duty_b_i) |=> fan_drive_out_b == $past(duty_b_i);
  endproperty
  a_pass_b: assert property (p_pass_b) else $error("out b not normal duty");
  property p_ready; pready_o == (ce_i && psel_i && penable_i); endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_err_phase; pslverr_o |-> psel_i && penable_i; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_zero; pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  property p_freeze; !ce_i |=> $stable(boost_active_o) && $stable(fan_drive_out_b); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low");
endmodule // mffb_top_chk

bind mffb_top mffb_top_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .duty_a_i(duty_a_i), .duty_b_i(duty_b_i),
  .fan_drive_out_a(fan_drive_out_a), .fan_drive_out_b(fan_drive_out_b),
  .boost_active_o(boost_active_o));

// >>> tb/mffb_sensor_model.sv
// Purpose: diodes, rails and tach counters feeding the block
// Assumes: one-cycle valid pulses on mclk_i
// Notes: idle fields flip so stale data never looks valid
`timescale 1ns/1ps
module mffb_sensor_model (
  input wire logic mclk_i,
  output mffb_pkg::mffb_temp_conv_t temp_o,
  output mffb_pkg::mffb_volt_conv_t volt_o,
  output mffb_pkg::mffb_tach_meas_t tach_o
);
  initial begin
    temp_o = '0;
    volt_o = '0;
    tach_o = '0;
  end
  task automatic temp(input logic [1:0] z, input logic oc, input logic sc, input logic [8:0] th,
    input logic [11:0] ts);
    @(posedge mclk_i);
    temp_o <= {1'b1, z, oc, sc, th, ts};
    @(posedge mclk_i);
    temp_o <= {1'b0, ~temp_o[24:0]};
  endtask
  task automatic volt(input logic [3:0] c, input logic [7:0] code);
    @(posedge mclk_i);
    volt_o <= {1'b1, c, code};
    @(posedge mclk_i);
    volt_o <= {1'b0, ~volt_o[11:0]};
  endtask
  task automatic tach(input logic [1:0] f, input logic [15:0] n);
    @(posedge mclk_i);
    tach_o <= {1'b1, f, n};
    @(posedge mclk_i);
    tach_o <= {1'b0, ~tach_o[17:0]};
  endtask
endmodule // mffb_sensor_model

// >>> tb/test_mffb_top.sv
// Purpose: self-checking bench for mffb_top
// Assumes: zero-wait APB, TICK_CYCLES of 4
// Notes: fixed waits cover the four-cycle conversion pipeline
`timescale 1ns/1ps
module test_mffb_top;
  typedef struct packed {
    logic k;
    logic [3:0] c;
    logic [1:0] f;
    logic [8:0] th;
    logic [11:0] ts;
    logic [31:0] e;
  } mffb_row_t;
  logic clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, er;
  logic [7:0] pa = '0, fa, fb;
  logic [31:0] pwd = '0, prd, rd;
  logic prdy, perr;
  logic [1:0] bo;
  mffb_pkg::mffb_temp_conv_t tc;
  mffb_pkg::mffb_volt_conv_t vc;
  mffb_pkg::mffb_tach_meas_t tm;
  int n_errors = 0, compares = 0;
  mffb_row_t rows [10] = '{
    {1'b0, 4'd0, 2'b00, 9'h0fb, 12'h7d1, 32'h7d10_7d80},
    {1'b0, 4'd1, 2'b00, 9'h1ff, 12'hfff, 32'hfff0_ff80},
    {1'b0, 4'd2, 2'b00, 9'h103, 12'h80f, 32'h80f0_8180},
    {1'b0, 4'd3, 2'b00, 9'h033, 12'h191, 32'h1910_1980},
    {1'b0, 4'd1, 2'b10, 9'h032, 12'h0, 32'h0},
    {1'b0, 4'd2, 2'b01, 9'h032, 12'h0, 32'h0},
    {1'b1, 4'd0, 2'b00, 9'h0c0, 12'h0, 32'hc0},
    {1'b1, 4'd1, 2'b00, 9'h0ff, 12'h0, 32'hff},
    {1'b1, 4'd3, 2'b00, 9'h000, 12'h0, 32'h0},
    {1'b1, 4'd8, 2'b00, 9'h040, 12'h0, 32'h40}};
  logic [39:0] rv [6] = '{{8'h00, 32'h00ff_ff00}, {8'h04, 32'h2323_3c3c},
    {8'h08, 32'h8080_8080}, {8'h0c, 32'hffff_ffff}, {8'h40, 32'h0000_ff00}, {8'hfc, 32'h0}};
  always #20 clk = ~clk;
  mffb_sensor_model pm (.mclk_i(clk), .temp_o(tc), .volt_o(vc), .tach_o(tm));
  mffb_top #(.TICK_CYCLES(4)) uut (.mclk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .temp_conv_i(tc), .volt_conv_i(vc), .tach_meas_i(tm),
    .duty_a_i(8'h33), .duty_b_i(8'h55), .fan_drive_out_a(fa), .fan_drive_out_b(fb),
    .boost_active_o(bo));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    i = 0;
    // ready, read data and error are taken at the rising edge that ends the access
    do begin
      @(posedge clk);
      i++;
    end while (prdy !== 1'b1 && i < 20);
    if (prdy !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic tz(input logic [8:0] th, input logic [1:0] e);
    pm.temp(2'd0, 1'b0, 1'b0, th, 12'h0);
    repeat (5) @(posedge clk);
    chk(bo, e, "temp boost");
    chk({fa, fb}, e[0] ? 16'hffff : 16'h3355, "drive");
  endtask
  initial begin
    mffb_row_t r;
    int j;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    foreach (rv[j]) begin
      apb(0, rv[j][39:32], 0);
      chk(rd, rv[j][31:0], "reset value");
    end
    chk(er, 1'b1, "unmapped");
    $display("end reset values");
    foreach (rows[j]) begin
      r = rows[j];
      if (r.k) begin
        pm.volt(r.c, r.th[7:0]);
        repeat (4) @(posedge clk);
        apb(0, mffb_pkg::OFS_VOLT + 8'(4 * r.c), 0);
        chk(rd, r.e, "volt code");
      end else begin
        pm.temp(r.c[1:0], r.f[1], r.f[0], r.th, r.ts);
        repeat (4) @(posedge clk);
        apb(0, mffb_pkg::OFS_TEMP8, 0);
        chk(rd[8*r.c +: 8], (r.f != 0) ? 8'h80 : r.e[15:8], "temp byte");
        apb(0, (r.f != 0) ? mffb_pkg::OFS_STAT_B : mffb_pkg::OFS_EXT + 8'(4 * r.c), 0);
        if (r.f != 0) chk(rd[r.c], 1'b1, "diode fault");
        else chk(rd, r.e, "extended");
      end
    end
    $display("end format rows");
    apb(1, mffb_pkg::OFS_STAT_B, '1);
    apb(1, mffb_pkg::OFS_CTRL, 32'h00ff_ff50);
    // zone 0 was left at 125 degrees by the format rows, so drop it below release first
    tz(9'h060, 2'b00);
    tz(9'h078, 2'b00);
    tz(9'h07a, 2'b11);
    apb(0, mffb_pkg::OFS_STAT_B, 0);
    chk(rd[4], 1'b0, "masked limit");
    apb(1, mffb_pkg::OFS_TLIM, 32'h8080_8032);
    tz(9'h07a, 2'b11);
    apb(0, mffb_pkg::OFS_STAT_B, 0);
    chk(rd[4], 1'b1, "limit B");
    apb(0, mffb_pkg::OFS_STAT_H, 0);
    chk(rd[4], 1'b1, "limit H");
    tz(9'h070, 2'b11);
    tz(9'h06e, 2'b00);
    $display("end temp boost");
    apb(1, mffb_pkg::OFS_CTRL, 32'h0040_2e51);
    apb(1, mffb_pkg::OFS_TACHLIM01, 32'hffff_1000);
    pm.tach(2'd0, 16'h1000);
    repeat (5) @(posedge clk);
    chk(bo, 2'b00, "tach at limit");
    pm.tach(2'd0, 16'h1001);
    repeat (5) @(posedge clk);
    chk({bo, fa, fb}, {2'b10, 16'h33ff}, "tach boost");
    pm.tach(2'd0, 16'h0800);
    repeat (3) @(posedge clk);
    chk(bo, 2'b10, "hold");
    repeat (6) @(posedge clk);
    pm.tach(2'd0, 16'h1001);
    pm.tach(2'd0, 16'h0800);
    repeat (11) @(posedge clk);
    chk(bo, 2'b10, "restart");
    for (j = 0; j < 40 && bo !== 2'b00; j++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({bo, fb}, {2'b00, 8'h55}, "release");
    $display("end tach boost");
    ce <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    $display("end clock enable");
    tally_and_finish();
  end
endmodule // test_mffb_top
